// ==== include/sis_pkg.sv ====
/*
 * package for the system integrity control/status register block:
 * register offsets, bit positions, reset values and bus response codes.
 * assumes an AXI4-Lite slave with 32-bit data, one register per aligned word.
 */
package sis_pkg;

    // byte addresses on the register bus
    localparam logic [3:0] OFF_CTRL_STATUS = 4'h0;
    localparam logic [3:0] OFF_CAUSE = 4'h4;
    localparam logic [3:0] OFF_STRAPS = 4'h8;

    // shared bit
    localparam int BIT_PAGE = 7;
    // page 0
    localparam int BIT_WARN_IE = 6;
    localparam int BIT_WARN_FLAG = 5;
    localparam int BIT_SUP_RST = 4;
    localparam int BIT_GUARD_IE = 2;
    localparam int BIT_GUARD_DET = 1;
    localparam int BIT_WDG_RST = 0;
    // page 1
    localparam int BIT_FREERUN = 5;
    localparam int BIT_LOCK = 4;
    localparam int BIT_PLL_EN = 3;
    localparam int BIT_CLK_SEL = 1;

    localparam logic [7:0] RESET_PAGE0 = 8'h00;
    localparam logic [7:0] RESET_PAGE1 = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // status inputs from the analog detectors, clock detector and pll
    typedef struct packed {
        logic warn_level;
        logic osc_failed;
        logic osc_recovered;
        logic pll_locked;
    } sis_status_t;

    // reset cause and option levels, sampled by the reset logic
    typedef struct packed {
        logic supply_rst;
        logic wdg_rst;
        logic supervisor_opt;
        logic pll_opt;
        logic in_circuit;
    } sis_cause_t;

    // controls driven out to the clock tree
    typedef struct packed {
        logic pll_enable;
        logic freerun;
        logic use_pll_clk;
    } sis_clk_ctrl_t;

endpackage

// ==== verification/tb_top.sv ====
/*
 * self-checking bench for the integrity control/status register block.
 * assumes the single-clock AXI4-Lite slave of sis_regs and status inputs
 * that need three edges before the register reflects them.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end

module tb_top;
    localparam int LIM = 64;
    localparam logic [1:0] OK = sis_pkg::RESP_OKAY;
    localparam logic [1:0] ER = sis_pkg::RESP_SLVERR;
    typedef struct {
        logic [3:0] a;
        logic [7:0] wd;
        logic [31:0] rd;
        logic [1:0] br;
        logic [1:0] rr;
        logic [2:0] clk;
    } sis_row_t;

    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, warn_irq, guard_irq;
    logic warn_irq_ack = 1'h0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    sis_pkg::sis_status_t st = '0;
    sis_pkg::sis_cause_t cs = '0;
    sis_pkg::sis_clk_ctrl_t ck;
    int checked = 0;
    int bad_count = 0;
    sis_row_t rows [10] = '{
        '{4'h0, 8'h44, 32'h0000_0044, OK, OK, 3'h0},
        '{4'h0, 8'h80, 32'h0000_0080, OK, OK, 3'h0},
        '{4'h0, 8'ha8, 32'h0000_00b8, OK, OK, 3'h6},
        '{4'h0, 8'h8a, 32'h0000_009a, OK, OK, 3'h5},
        '{4'h0, 8'h80, 32'h0000_0098, OK, OK, 3'h4},
        '{4'h0, 8'h80, 32'h0000_0080, OK, OK, 3'h0},
        '{4'h8, 8'hff, 32'h0000_0004, OK, OK, 3'h0},
        '{4'hc, 8'h00, 32'h0000_0000, ER, ER, 3'h0},
        '{4'h0, 8'h00, 32'h0000_0000, OK, OK, 3'h0},
        '{4'h0, 8'h04, 32'h0000_0004, OK, OK, 3'h0}
    };

    always #20 aclk = ~aclk;

    sis_regs dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .status_in(st), .cause_in(cs), .warn_irq_ack(warn_irq_ack),
        .warn_irq(warn_irq), .guard_irq(guard_irq), .clk_ctrl(ck)
    );

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // entry edge first, so a release at the previous exit is never overwritten
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d}; // callers keep reserved bits zero, except the 8'hff write to the read-only straps word
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < LIM; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                bready <= 1'h0;
                `CHK(bresp, er)
                break;
            end
        end
        if (n == LIM) begin
            bad_count++;
            close_out();
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < LIM; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                rready <= 1'h0;
                `CHK(rdata, ed)
                `CHK(rresp, er)
                break;
            end
        end
        if (n == LIM) begin
            bad_count++;
            close_out();
        end
    endtask

    // two sync stages plus one edge to act, with one edge of margin
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask

    task automatic ack();
        warn_irq_ack <= 1'h1;
        @(posedge aclk);
        warn_irq_ack <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic cause_pulse(input logic sup);
        if (sup) cs.supply_rst <= 1'h1;
        else cs.wdg_rst <= 1'h1;
        settle();
        cs.supply_rst <= 1'h0;
        cs.wdg_rst <= 1'h0;
        settle();
    endtask

    initial begin
        st.pll_locked <= 1'h1;
        cs.supervisor_opt <= 1'h1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].a, rows[i].wd, rows[i].br);
            rd(rows[i].a, rows[i].rd, rows[i].rr);
            `CHK(ck, rows[i].clk)
        end
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(4'h0, 32'h0000_0000, OK);
        `CHK(ck, 3'h0)
        // warning interrupt in both directions, then with the supervisor off
        wr(4'h0, 8'h40, OK);
        st.warn_level <= 1'h1;
        settle();
        rd(4'h0, 32'h0000_0060, OK);
        `CHK(warn_irq, 1'h1)
        rd(4'h4, 32'h0000_0003, OK);
        ack();
        `CHK(warn_irq, 1'h0)
        rd(4'h4, 32'h0000_0000, OK);
        st.warn_level <= 1'h0;
        settle();
        `CHK(warn_irq, 1'h1)
        rd(4'h0, 32'h0000_0040, OK);
        ack();
        cs.supervisor_opt <= 1'h0;
        st.warn_level <= 1'h1;
        settle();
        rd(4'h0, 32'h0000_0040, OK);
        `CHK(warn_irq, 1'h0)
        cs.supervisor_opt <= 1'h1;
        st.warn_level <= 1'h0;
        settle();
        wr(4'h0, 8'h00, OK);
        // reset-source flags
        cause_pulse(1'h0);
        rd(4'h0, 32'h0000_0001, OK);
        cause_pulse(1'h1);
        rd(4'h0, 32'h0000_0010, OK);
        cause_pulse(1'h0);
        rd(4'h0, 32'h0000_0011, OK);
        wr(4'h0, 8'h01, OK);
        rd(4'h0, 32'h0000_0001, OK);
        wr(4'h0, 8'h10, OK);
        rd(4'h0, 32'h0000_0000, OK);
        // clock guard: masked without pll, sticky until recovery
        wr(4'h0, 8'h04, OK);
        st.osc_failed <= 1'h1;
        settle();
        rd(4'h0, 32'h0000_0004, OK);
        `CHK(guard_irq, 1'h0)
        st.osc_failed <= 1'h0;
        settle();
        wr(4'h0, 8'h84, OK);
        wr(4'h0, 8'h88, OK);
        wr(4'h0, 8'h08, OK);
        st.osc_failed <= 1'h1;
        settle();
        st.osc_failed <= 1'h0;
        settle();
        rd(4'h0, 32'h0000_0006, OK);
        `CHK(guard_irq, 1'h1)
        rd(4'h0, 32'h0000_0006, OK);
        st.osc_recovered <= 1'h1;
        settle();
        rd(4'h0, 32'h0000_0006, OK);
        rd(4'h0, 32'h0000_0004, OK);
        `CHK(guard_irq, 1'h0)
        st.osc_recovered <= 1'h0;
        // clock selection, option and in-circuit forcing
        wr(4'h0, 8'h80, OK);
        wr(4'h0, 8'h82, OK);
        rd(4'h0, 32'h0000_0082, OK);
        `CHK(ck.use_pll_clk, 1'h0)
        cs.pll_opt <= 1'h1;
        settle();
        wr(4'h0, 8'h88, OK);
        rd(4'h0, 32'h0000_0098, OK);
        `CHK(ck.use_pll_clk, 1'h1)
        cs.pll_opt <= 1'h0;
        cs.in_circuit <= 1'h1;
        settle();
        rd(4'h0, 32'h0000_00ba, OK);
        `CHK(ck, 3'h7)
        cs.in_circuit <= 1'h0;
        settle();
        wr(4'h0, 8'h80, OK);
        rd(4'h0, 32'h0000_0098, OK);
        // a write without byte lane 0 leaves the register alone
        wstrb <= 4'h0;
        wr(4'h0, 8'h00, OK);
        wstrb <= 4'hf;
        rd(4'h0, 32'h0000_0098, OK);
        close_out();
    end
endmodule

`default_nettype wire

// ==== verilog/sis_regs.sv ====
/*
 * system integrity control/status register, two pages behind one word,
 * reached over AXI4-Lite; drives the warning and clock-guard interrupt
 * requests and the pll controls.
 * assumes status and cause inputs are asynchronous to aclk and that the
 * cpu supplies a one-cycle pulse when it enters the warning service routine.
 */
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - bit 7 selects page; 0 page-0 layout, 1 page-1 layout at same address.
// - warning irq enable set: request on every warning flag change, both ways.
// - pending warning request clears when cpu enters its service routine.
// - warning flag is read-only, follows hardware: 1 means supply below threshold.
// - supply reset flag set by supply reset; software clears by writing zero.
// - supply reset flag undefined when supervisor option off; do not rely.
// - clock guard irq enable gates detection interrupt; no effect without pll.
// - guard detect set on oscillator failure; read clears only after recovery.
// - guard detect reads zero while pll enable is zero.
// - watchdog flag set by watchdog reset; cleared by zero write or supply reset.
// - two reset flags encode source: pin, watchdog, or supply.
// - supply reset flag survives later external or watchdog resets.
// - free-run bit 0 closes pll loop, 1 gives free-running oscillator.
// - in-circuit session forces free-run, pll enable and clock select to 1.
// - pll lock bit is read-only, set by hardware once locked.
// - pll enable turns on both pll and clock detector.
// - pll enable cannot be cleared while clock select is 1.
// - clock select 0 oscillator, 1 pll; writable, presettable by option (here the bit is not preset; pll_opt is ORed into use_pll_clk).
// - never switch to pll clock while pll enable is zero.
// - when option fixes the clock source, select writes do not affect it.
// - warning detector, flag and interrupt active only with supervisor option.
module sis_regs (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // hardware status and reset cause
    input wire sis_pkg::sis_status_t status_in,
    input wire sis_pkg::sis_cause_t cause_in,
    // cpu enters warning service routine
    input wire logic warn_irq_ack,
    // interrupt requests and clock controls
    output logic warn_irq,
    output logic guard_irq,
    output sis_pkg::sis_clk_ctrl_t clk_ctrl
);

    // two-flop synchronisers for everything that comes from outside aclk
    localparam int NSYNC = $bits(sis_pkg::sis_status_t) + $bits(sis_pkg::sis_cause_t);
    logic [NSYNC-1:0] meta_q, meta_d, sync_q, sync_d;
    sis_pkg::sis_status_t st;
    sis_pkg::sis_cause_t cs;

    always_comb begin
        meta_d = {status_in, cause_in};
        sync_d = meta_q;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign {st, cs} = sync_q;

    // register state
    logic page_q, page_d;
    logic warn_ie_q, warn_ie_d;
    logic sup_rst_q, sup_rst_d;
    logic guard_ie_q, guard_ie_d;
    logic guard_det_q, guard_det_d;
    logic wdg_rst_q, wdg_rst_d;
    logic freerun_q, freerun_d;
    logic pll_en_q, pll_en_d;
    logic clk_sel_q, clk_sel_d;
    logic warn_prev_q, warn_prev_d;
    logic warn_pend_q, warn_pend_d;
    logic sup_rst_prev_q, sup_rst_prev_d, wdg_prev_q, wdg_prev_d;

    // bus handshake state
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [3:0] aw_addr_q, aw_addr_d;
    logic [7:0] w_byte_q, w_byte_d;
    logic w_lane0_q, w_lane0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    logic warn_level, warn_edge, guard_view, wr_go, rd_go, wr_reg, rd_reg;
    logic [7:0] page0_view, page1_view, reg_view;

    // detector only counts with the supervisor option on
    assign warn_level = cs.supervisor_opt & st.warn_level;
    assign warn_edge = warn_level ^ warn_prev_q;
    assign guard_view = guard_det_q & pll_en_q;

    always_comb begin
        page0_view = sis_pkg::RESET_PAGE0;
        page0_view[sis_pkg::BIT_PAGE] = page_q;
        page0_view[sis_pkg::BIT_WARN_IE] = warn_ie_q;
        page0_view[sis_pkg::BIT_WARN_FLAG] = warn_level;
        page0_view[sis_pkg::BIT_SUP_RST] = sup_rst_q;
        page0_view[sis_pkg::BIT_GUARD_IE] = guard_ie_q;
        page0_view[sis_pkg::BIT_GUARD_DET] = guard_view;
        page0_view[sis_pkg::BIT_WDG_RST] = wdg_rst_q;
        page1_view = sis_pkg::RESET_PAGE1;
        page1_view[sis_pkg::BIT_PAGE] = page_q;
        page1_view[sis_pkg::BIT_FREERUN] = freerun_q;
        page1_view[sis_pkg::BIT_LOCK] = st.pll_locked & pll_en_q;
        page1_view[sis_pkg::BIT_PLL_EN] = pll_en_q;
        page1_view[sis_pkg::BIT_CLK_SEL] = clk_sel_q;
        reg_view = page_q ? page1_view : page0_view;
    end

    // write takes both channels in either order; response after both
    assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_reg = wr_go & (aw_addr_q == sis_pkg::OFF_CTRL_STATUS) & w_lane0_q;
    assign rd_go = s_axi_arvalid & ~rvalid_q;
    assign rd_reg = rd_go & (s_axi_araddr == sis_pkg::OFF_CTRL_STATUS);

    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        aw_addr_d = aw_addr_q;
        w_byte_d = w_byte_q;
        w_lane0_d = w_lane0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_d = 1'b1;
            w_byte_d = s_axi_wdata[7:0];
            w_lane0_d = s_axi_wstrb[0];
        end
        if (wr_go) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (aw_addr_q[3:2] <= sis_pkg::OFF_STRAPS[3:2]) ?
                sis_pkg::RESP_OKAY : sis_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d = sis_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                sis_pkg::OFF_CTRL_STATUS: rdata_d = {24'h00_0000, reg_view};
                sis_pkg::OFF_CAUSE: rdata_d = {30'h0000_0000, warn_pend_q, warn_irq};
                sis_pkg::OFF_STRAPS: rdata_d = {27'h000_0000, cs};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = sis_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_comb begin
        page_d = page_q;
        warn_ie_d = warn_ie_q;
        sup_rst_d = sup_rst_q;
        guard_ie_d = guard_ie_q;
        guard_det_d = guard_det_q;
        wdg_rst_d = wdg_rst_q;
        freerun_d = freerun_q;
        pll_en_d = pll_en_q;
        clk_sel_d = clk_sel_q;
        warn_prev_d = warn_level;
        warn_pend_d = warn_pend_q;
        sup_rst_prev_d = cs.supply_rst;
        wdg_prev_d = cs.wdg_rst;

        if (wr_reg) begin
            page_d = w_byte_q[sis_pkg::BIT_PAGE];
            if (!page_q) begin
                warn_ie_d = w_byte_q[sis_pkg::BIT_WARN_IE];
                guard_ie_d = w_byte_q[sis_pkg::BIT_GUARD_IE];
                // flags only accept zero; writing one leaves them
                if (!w_byte_q[sis_pkg::BIT_SUP_RST]) sup_rst_d = 1'b0;
                if (!w_byte_q[sis_pkg::BIT_WDG_RST]) wdg_rst_d = 1'b0;
            end else begin
                freerun_d = w_byte_q[sis_pkg::BIT_FREERUN];
                clk_sel_d = w_byte_q[sis_pkg::BIT_CLK_SEL];
                // pll stays on while clock select is 1
                pll_en_d = w_byte_q[sis_pkg::BIT_PLL_EN] | clk_sel_q;
            end
        end

        // read of page 0 clears detection only once the oscillator is back
        if (rd_reg && !page_q && st.osc_recovered) guard_det_d = 1'b0;
        if (pll_en_q && st.osc_failed) guard_det_d = 1'b1;
        if (!pll_en_q) guard_det_d = 1'b0;

        // cause flags rise on the reset event edge; set wins over a zero write
        // with the supervisor option off the supply flag carries no meaning
        if (cs.wdg_rst && !wdg_prev_q) wdg_rst_d = 1'b1;
        if (cs.supply_rst && !sup_rst_prev_q) begin
            sup_rst_d = 1'b1;
            wdg_rst_d = 1'b0;
        end

        // acknowledge clears, a fresh edge in the same cycle wins
        if (warn_irq_ack) warn_pend_d = 1'b0;
        if (warn_ie_q && warn_edge) warn_pend_d = 1'b1;
        if (!cs.supervisor_opt) warn_pend_d = 1'b0;

        if (cs.in_circuit) begin
            freerun_d = 1'b1;
            pll_en_d = 1'b1;
            clk_sel_d = 1'b1;
        end
    end

    // aresetn clears the cause flags too: the reset logic re-raises them
    // through cause_in after release, which keeps supply evidence intact
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_q <= 1'b0;
            warn_ie_q <= 1'b0;
            sup_rst_q <= 1'b0;
            guard_ie_q <= 1'b0;
            guard_det_q <= 1'b0;
            wdg_rst_q <= 1'b0;
            freerun_q <= 1'b0;
            pll_en_q <= 1'b0;
            clk_sel_q <= 1'b0;
            warn_prev_q <= 1'b0;
            warn_pend_q <= 1'b0;
            sup_rst_prev_q <= 1'b0;
            wdg_prev_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else begin
            page_q <= page_d;
            warn_ie_q <= warn_ie_d;
            sup_rst_q <= sup_rst_d;
            guard_ie_q <= guard_ie_d;
            guard_det_q <= guard_det_d;
            wdg_rst_q <= wdg_rst_d;
            freerun_q <= freerun_d;
            pll_en_q <= pll_en_d;
            clk_sel_q <= clk_sel_d;
            warn_prev_q <= warn_prev_d;
            warn_pend_q <= warn_pend_d;
            sup_rst_prev_q <= sup_rst_prev_d;
            wdg_prev_q <= wdg_prev_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            aw_addr_q <= aw_addr_d;
            w_byte_q <= w_byte_d;
            w_lane0_q <= w_lane0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    assign warn_irq = warn_pend_q;
    assign guard_irq = guard_ie_q & guard_view & pll_en_q;
    always_comb begin
        clk_ctrl.pll_enable = pll_en_q;
        clk_ctrl.freerun = freerun_q;
        // option wins over the bit; pll clock only with pll running
        clk_ctrl.use_pll_clk = (cs.pll_opt | clk_sel_q) & pll_en_q;
    end

    AST_PAGE_SWITCH: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_reg |=> page_q == $past(w_byte_q[sis_pkg::BIT_PAGE]))
        else $error("page bit did not follow write");
    AST_WARN_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
        warn_ie_q && warn_edge && cs.supervisor_opt |=> warn_irq)
        else $error("warning change without request");
    AST_WARN_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
        warn_irq_ack && !warn_edge |=> !warn_irq)
        else $error("warning request survived acknowledge");
    AST_GUARD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        !pll_en_q |-> !guard_view && !guard_irq)
        else $error("guard detect visible with pll off");
    AST_GUARD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        guard_det_q && pll_en_q && !st.osc_recovered ##1 pll_en_q |-> guard_det_q)
        else $error("guard detect cleared before recovery");
    AST_PLL_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_sel_q && pll_en_q |=> pll_en_q)
        else $error("pll disabled while selected");
    AST_NO_PLL_CLK: assert property (@(posedge aclk) disable iff (!aresetn)
        clk_ctrl.use_pll_clk |-> pll_en_q)
        else $error("pll clock used while pll disabled");
    AST_SUP_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        cs.supply_rst && !sup_rst_prev_q |=> sup_rst_q && !wdg_rst_q)
        else $error("supply reset flags wrong");
    AST_ICC_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
        cs.in_circuit |=> freerun_q && pll_en_q && clk_sel_q)
        else $error("session did not force clock bits");
    AST_GUARD_READ_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_reg && !page_q && !pll_en_q |=> !s_axi_rdata[sis_pkg::BIT_GUARD_DET])
        else $error("guard detect read as set with pll off");
    AST_WARN_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_reg && !page_q |=> s_axi_rdata[sis_pkg::BIT_WARN_FLAG] == $past(warn_level))
        else $error("warning flag read does not follow detector");
    AST_SEL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_reg && page_q && !cs.in_circuit |=> clk_sel_q == $past(w_byte_q[sis_pkg::BIT_CLK_SEL]))
        else $error("clock select did not follow write");
    AST_WDG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        cs.wdg_rst && !wdg_prev_q && !cs.supply_rst |=> wdg_rst_q)
        else $error("watchdog flag not set by watchdog reset");
    AST_SUP_KEEP: assert property (@(posedge aclk) disable iff (!aresetn)
        sup_rst_q && !wr_reg |=> sup_rst_q)
        else $error("supply reset flag lost without a write");
    AST_WARN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        !cs.supervisor_opt |=> !warn_irq)
        else $error("warning request with supervisor option off");
    AST_GUARD_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
        guard_ie_q && guard_det_q && pll_en_q |-> guard_irq)
        else $error("enabled guard detection without request");

endmodule

`default_nettype wire
